/* File: src/sec_consts.svh */
// Constants of the serial EEPROM command interface: opcodes, field widths and timing.
// Assumes inclusion by bare name from the package and the design module.
`ifndef SEC_CONSTS_SVH
`define SEC_CONSTS_SVH

`define SEC_OP_SYS       2'b00
`define SEC_OP_WRITE     2'b01
`define SEC_OP_READ      2'b10
`define SEC_OP_ERASE     2'b11
`define SEC_SUB_LOCK     2'b00
`define SEC_SUB_FILL     2'b01
`define SEC_SUB_CLEAR    2'b10
`define SEC_SUB_UNLOCK   2'b11
`define SEC_OP_BITS      2
`define SEC_ADDR16_BITS  8
`define SEC_ADDR8_BITS   9
`define SEC_DATA16_BITS  16
`define SEC_DATA8_BITS   8
`define SEC_CLK_NS       10
`define SEC_TCS_NS       200
`define SEC_TCS_CYC      ((`SEC_TCS_NS + `SEC_CLK_NS - 1) / `SEC_CLK_NS)
`define SEC_PROG_CYC     50000

`endif

/* File: src/sec_pkg.sv */
// Types shared by the serial EEPROM command interface.
// Assumes sec_consts.svh sits in the include path.
`include "sec_consts.svh"

package sec_pkg;

  typedef enum logic [2:0] {
    SEC_K_NONE,
    SEC_K_WRITE,
    SEC_K_ERASE,
    SEC_K_FILL,
    SEC_K_CLEAR,
    SEC_K_UNLOCK,
    SEC_K_LOCK
  } sec_kind_e;

  typedef enum logic [4:0] {
    SEC_L_IDLE = 5'b00001,
    SEC_L_CMD  = 5'b00010,
    SEC_L_DATA = 5'b00100,
    SEC_L_READ = 5'b01000,
    SEC_L_DONE = 5'b10000
  } sec_lst_e;

  typedef enum logic [1:0] {
    SEC_S_IDLE = 2'b01,
    SEC_S_BUSY = 2'b10
  } sec_sst_e;

  typedef struct packed {
    sec_kind_e   kind;
    logic [8:0]  addr;
    logic [15:0] data;
  } sec_cmd_s;

endpackage : sec_pkg

/* File: src/sec_eeprom.sv */
// Serial EEPROM command interface: three-wire link front end and self-timed array.
// Assumes i_serial_clock comes from the host and stops outside frames, i_cs frames commands.
`timescale 1ns/1ps
`include "sec_consts.svh"

module sec_eeprom #(
  parameter int unsigned PROG_CYCLES = `SEC_PROG_CYC,
  parameter int unsigned ADDR16_W    = `SEC_ADDR16_BITS
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_serial_clock,
  input  wire logic i_cs,
  input  wire logic i_din,
  input  wire logic i_org,
  output logic      o_dout,
  output logic      o_dout_oe
);
  import sec_pkg::*;

  localparam int unsigned WORDS  = 1 << ADDR16_W;
  localparam int unsigned TCS_CY = `SEC_TCS_CYC;

  function automatic sec_kind_e decode_kind(input logic [1:0] op, input logic [1:0] sub);
    sec_kind_e k;
    k = SEC_K_NONE;
    case (op)
      `SEC_OP_WRITE: k = SEC_K_WRITE;
      `SEC_OP_ERASE: k = SEC_K_ERASE;
      `SEC_OP_SYS: begin
        case (sub)
          `SEC_SUB_UNLOCK: k = SEC_K_UNLOCK;
          `SEC_SUB_FILL:   k = SEC_K_FILL;
          `SEC_SUB_CLEAR:  k = SEC_K_CLEAR;
          default:         k = SEC_K_LOCK;
        endcase
      end
      default: k = SEC_K_NONE;
    endcase
    return k;
  endfunction : decode_kind

  ////////////////////////////////////////////////////////////////////////////////
  // Link side, clocked by the host's serial clock.

  // Registers owned by the system clock, declared here because the link reads them.
  logic        org_r;
  logic        rst_link_n_r;
  logic [15:0] rd_data_r;

  sec_lst_e    lst_r,    lst_nxt;
  logic [4:0]  lcnt_r,   lcnt_nxt;
  logic [15:0] lsh_r,    lsh_nxt;
  logic [15:0] rsh_r,    rsh_nxt;
  logic        ldout_r,  ldout_nxt;
  logic [8:0]  raddr_r,  raddr_nxt;
  logic        rtgl_r,   rtgl_nxt;
  logic        stgl_r,   stgl_nxt;
  logic        atgl_r,   atgl_nxt;
  logic        arm_r,    arm_nxt;
  sec_cmd_s    cmd_r,    cmd_nxt;

  logic [4:0]  cmd_len;
  logic [4:0]  dat_len;
  logic [1:0]  op_f;
  logic [1:0]  sub_f;
  logic [8:0]  addr_f;
  logic [8:0]  addr_mask;
  sec_kind_e   kind_f;

  // The strap is captured while reset is held and then static, so the link reads it directly.
  always_comb begin
    cmd_len   = org_r ? 5'd10 : 5'd11;
    dat_len   = org_r ? 5'(`SEC_DATA16_BITS) : 5'(`SEC_DATA8_BITS);
    addr_mask = org_r ? 9'h0ff : 9'h1ff;
    lsh_nxt   = {lsh_r[14:0], i_din};
    op_f      = org_r ? lsh_nxt[9:8] : lsh_nxt[10:9];
    addr_f    = org_r ? {1'b0, lsh_nxt[7:0]} : lsh_nxt[8:0];
    sub_f     = org_r ? lsh_nxt[7:6] : lsh_nxt[8:7];
    kind_f    = decode_kind(op_f, sub_f);
    lst_nxt   = lst_r;
    lcnt_nxt  = lcnt_r;
    rsh_nxt   = rsh_r;
    ldout_nxt = ldout_r;
    raddr_nxt = raddr_r;
    rtgl_nxt  = rtgl_r;
    stgl_nxt  = stgl_r;
    atgl_nxt  = atgl_r;
    arm_nxt   = arm_r;
    cmd_nxt   = cmd_r;
    case (lst_r)
      SEC_L_IDLE: begin
        lsh_nxt = 16'h0000;
        if (i_din) begin
          stgl_nxt = ~stgl_r;
          arm_nxt  = 1'b0;
          lcnt_nxt = 5'd0;
          lst_nxt  = SEC_L_CMD;
        end
      end
      SEC_L_CMD: begin
        lcnt_nxt = lcnt_r + 5'd1;
        if (lcnt_r == cmd_len - 5'd1) begin
          lcnt_nxt = 5'd0;
          if (op_f == `SEC_OP_READ) begin
            raddr_nxt = addr_f;
            rtgl_nxt  = ~rtgl_r;
            ldout_nxt = 1'b0;
            lst_nxt   = SEC_L_READ;
          end else if (kind_f == SEC_K_WRITE || kind_f == SEC_K_FILL) begin
            cmd_nxt.kind = kind_f;
            cmd_nxt.addr = addr_f;
            lst_nxt      = SEC_L_DATA;
          end else begin
            cmd_nxt.kind = kind_f;
            cmd_nxt.addr = addr_f;
            cmd_nxt.data = 16'hffff;
            arm_nxt      = 1'b1;
            atgl_nxt     = ~atgl_r;
            lst_nxt      = SEC_L_DONE;
          end
        end
      end
      SEC_L_DATA: begin
        lcnt_nxt = lcnt_r + 5'd1;
        if (lcnt_r == dat_len - 5'd1) begin
          cmd_nxt.data = org_r ? lsh_nxt : {8'h00, lsh_nxt[7:0]};
          arm_nxt      = 1'b1;
          atgl_nxt     = ~atgl_r;
          lst_nxt      = SEC_L_DONE;
        end
      end
      SEC_L_READ: begin
        // One serial period separates the request toggle from the load below.
        if (lcnt_r == 5'd0) begin
          ldout_nxt = rd_data_r[15];
          rsh_nxt   = {rd_data_r[14:0], 1'b0};
        end else begin
          ldout_nxt = rsh_r[15];
          rsh_nxt   = {rsh_r[14:0], 1'b0};
        end
        lcnt_nxt = lcnt_r + 5'd1;
        if (lcnt_r == dat_len - 5'd1) begin
          lcnt_nxt  = 5'd0;
          raddr_nxt = (raddr_r + 9'd1) & addr_mask;
          rtgl_nxt  = ~rtgl_r;
        end
      end
      SEC_L_DONE: begin
        // Trailing bits are dropped; they withdraw a pending program command.
        arm_nxt = 1'b0;
      end
      default: begin
        lst_nxt = SEC_L_IDLE;
      end
    endcase
  end

  // Frame state clears when select falls, so the next frame starts clean.
  always_ff @(posedge i_serial_clock or negedge i_cs) begin
    if (!i_cs) begin
      lst_r   <= SEC_L_IDLE;
      lcnt_r  <= 5'd0;
      lsh_r   <= 16'h0000;
      rsh_r   <= 16'h0000;
      ldout_r <= 1'b0;
    end else begin
      lst_r   <= lst_nxt;
      lcnt_r  <= lcnt_nxt;
      lsh_r   <= lsh_nxt;
      rsh_r   <= rsh_nxt;
      ldout_r <= ldout_nxt;
    end
  end

  // Handover state must survive select falling, since the system side consumes it after.
  always_ff @(posedge i_serial_clock or negedge rst_link_n_r) begin
    if (!rst_link_n_r) begin
      raddr_r <= 9'h000;
      rtgl_r  <= 1'b0;
      stgl_r  <= 1'b0;
      atgl_r  <= 1'b0;
      arm_r   <= 1'b0;
      cmd_r   <= '{kind: SEC_K_NONE, addr: 9'h000, data: 16'h0000};
    end else if (i_cs) begin
      raddr_r <= raddr_nxt;
      rtgl_r  <= rtgl_nxt;
      stgl_r  <= stgl_nxt;
      atgl_r  <= atgl_nxt;
      arm_r   <= arm_nxt;
      cmd_r   <= cmd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers into the system clock.

  logic [1:0] cs_sy_r, org_sy_r, arm_sy_r;
  logic [2:0] atgl_sy_r, rtgl_sy_r, stgl_sy_r;
  logic       cs_d_r;

  always_ff @(posedge i_clk_sys) begin
    cs_sy_r   <= {cs_sy_r[0], i_cs};
    org_sy_r  <= {org_sy_r[0], i_org};
    arm_sy_r  <= {arm_sy_r[0], arm_r};
    atgl_sy_r <= {atgl_sy_r[1:0], atgl_r};
    rtgl_sy_r <= {rtgl_sy_r[1:0], rtgl_r};
    stgl_sy_r <= {stgl_sy_r[1:0], stgl_r};
    cs_d_r    <= cs_sy_r[1];
  end

  logic cs_s, cs_fall, arm_ev, rd_ev, start_ev;

  always_comb begin
    cs_s     = cs_sy_r[1];
    cs_fall  = cs_d_r & ~cs_sy_r[1];
    arm_ev   = atgl_sy_r[2] ^ atgl_sy_r[1];
    rd_ev    = rtgl_sy_r[2] ^ rtgl_sy_r[1];
    start_ev = stgl_sy_r[2] ^ stgl_sy_r[1];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // System side: enable flag, self-timed programming, array and status output.

  sec_sst_e    sst_r,    sst_nxt;
  logic [31:0] pcnt_r,   pcnt_nxt;
  logic        wen_r,    wen_nxt;
  logic        pend_r,   pend_nxt;
  logic        show_r,   show_nxt;
  sec_cmd_s    job_r,    job_nxt;
  logic [15:0] mem_r     [WORDS];
  logic [15:0] mem_nxt   [WORDS];
  logic [15:0] rd_nxt;
  logic        org_nxt;
  logic        st_oe_r,  st_oe_nxt;
  logic        st_do_r,  st_do_nxt;
  logic        is_prog;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic [ADDR16_W-1:0] widx;

  always_comb begin
    org_nxt   = i_rst_n ? org_r : org_sy_r[1];
    sst_nxt   = sst_r;
    pcnt_nxt  = pcnt_r;
    wen_nxt   = wen_r;
    // A frame that ends while busy is dropped, so its arm must not linger past its select fall.
    pend_nxt  = (pend_r | arm_ev) & ~cs_fall;
    show_nxt  = show_r;
    job_nxt   = job_r;
    mem_nxt   = mem_r;
    rd_nxt    = rd_data_r;
    is_prog   = (cmd_r.kind == SEC_K_WRITE) || (cmd_r.kind == SEC_K_ERASE) ||
                (cmd_r.kind == SEC_K_FILL)  || (cmd_r.kind == SEC_K_CLEAR);
    widx      = org_r ? job_r.addr[ADDR16_W-1:0] : job_r.addr[ADDR16_W:1];
    wmask     = org_r ? 16'hffff : (job_r.addr[0] ? 16'hff00 : 16'h00ff);
    wval      = org_r ? job_r.data : {job_r.data[7:0], job_r.data[7:0]};

    // Lock and unlock act as soon as they arrive; trailing bits cannot cancel them.
    if (arm_ev && cmd_r.kind == SEC_K_UNLOCK) begin
      wen_nxt = 1'b1;
    end
    if (arm_ev && cmd_r.kind == SEC_K_LOCK) begin
      wen_nxt = 1'b0;
    end

    if (rd_ev) begin
      if (org_r) begin
        rd_nxt = mem_r[raddr_r[ADDR16_W-1:0]];
      end else if (raddr_r[0]) begin
        rd_nxt = {mem_r[raddr_r[ADDR16_W:1]][15:8], 8'h00};
      end else begin
        rd_nxt = {mem_r[raddr_r[ADDR16_W:1]][7:0], 8'h00};
      end
    end

    // Status stays visible only while select is high, until the next start bit or until select is low while not busy.
    if (!cs_s && sst_r != SEC_S_BUSY) begin
      show_nxt = 1'b0;
    end
    if (start_ev) begin
      show_nxt = 1'b0;
    end

    case (sst_r)
      SEC_S_IDLE: begin
        if (cs_fall) begin
          pend_nxt = 1'b0;
          if ((pend_r || arm_ev) && arm_sy_r[1] && is_prog && wen_r) begin
            job_nxt  = cmd_r;
            pcnt_nxt = 32'd0;
            show_nxt = 1'b1;
            sst_nxt  = SEC_S_BUSY;
          end
        end
      end
      SEC_S_BUSY: begin
        pcnt_nxt = pcnt_r + 32'd1;
        if (pcnt_r == 32'd0) begin
          // Erase phase: the target, or the whole array, goes to all ones first.
          if (job_r.kind == SEC_K_FILL || job_r.kind == SEC_K_CLEAR) begin
            for (int i = 0; i < WORDS; i++) begin
              mem_nxt[i] = 16'hffff;
            end
          end else begin
            mem_nxt[widx] = mem_r[widx] | wmask;
          end
        end
        if (pcnt_r == 32'(PROG_CYCLES - 1)) begin
          sst_nxt = SEC_S_IDLE;
          if (job_r.kind == SEC_K_FILL) begin
            for (int i = 0; i < WORDS; i++) begin
              mem_nxt[i] = wval;
            end
          end else if (job_r.kind == SEC_K_WRITE) begin
            mem_nxt[widx] = (mem_r[widx] & ~wmask) | (wval & wmask);
          end
        end
      end
      default: begin
        sst_nxt = SEC_S_IDLE;
      end
    endcase

    // Host waits the select hold time before looking, so status is withheld until then.
    st_oe_nxt = cs_s && show_r && (sst_r != SEC_S_BUSY || pcnt_r >= 32'(TCS_CY));
    st_do_nxt = (sst_r != SEC_S_BUSY);
  end

  always_ff @(posedge i_clk_sys) begin
    rst_link_n_r <= i_rst_n;
    org_r        <= org_nxt;
    mem_r        <= mem_nxt;
    rd_data_r    <= rd_nxt;
    if (!i_rst_n) begin
      sst_r   <= SEC_S_IDLE;
      pcnt_r  <= 32'd0;
      wen_r   <= 1'b0;
      pend_r  <= 1'b0;
      show_r  <= 1'b0;
      job_r   <= '{kind: SEC_K_NONE, addr: 9'h000, data: 16'h0000};
      st_oe_r <= 1'b0;
      st_do_r <= 1'b0;
    end else begin
      sst_r   <= sst_nxt;
      pcnt_r  <= pcnt_nxt;
      wen_r   <= wen_nxt;
      pend_r  <= pend_nxt;
      show_r  <= show_nxt;
      job_r   <= job_nxt;
      st_oe_r <= st_oe_nxt;
      st_do_r <= st_do_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output pin: read data while reading, otherwise ready/busy when shown.

  always_comb begin
    o_dout_oe = (lst_r == SEC_L_READ) | st_oe_r;
    o_dout    = (lst_r == SEC_L_READ) ? ldout_r : (st_oe_r & st_do_r);
  end

endmodule : sec_eeprom

/* File: testbench/sec_host_model.sv */
// Host model: drives select, link clock and serial data, samples the serial output.
// Assumes one task at a time; the link clock idles low outside frames.
`timescale 1ns/1ps
module sec_host_model (
  output logic     o_sck,
  output logic     o_cs,
  output logic     o_din,
  input wire logic i_dout
);
  initial begin
    o_sck = 1'b0;
    o_cs  = 1'b0;
    o_din = 1'b0;
  end
  ////////////////////////////////////////
  // Select rises and data settles well ahead of each rising edge.
  task automatic frame(input logic [31:0] bits, input int n, input int nout,
                       input int stall, output logic [63:0] got);
    got = 64'h0;
    o_cs = 1'b1;
    #33.7;
    for (int i = 0; i < n + nout; i++) begin
      // Past the command the line toggles so a stale level is never mistaken for data.
      o_din = (i < n) ? bits[n - 1 - i] : ~o_din;
      #80 o_sck = 1'b1;
      #80;
      if (i >= n - 1) got = {got[62:0], i_dout};
      o_sck = 1'b0;
      if (i == stall) #2000;
    end
    cs_dn();
  endtask : frame
  task automatic cs_up();
    o_cs = 1'b1;
  endtask : cs_up
  // Select stays low long enough for the frame logic to settle.
  task automatic cs_dn();
    o_cs = 1'b0;
    o_din = ~o_din;
    #100;
  endtask : cs_dn
  task automatic clr();
    o_din = 1'b1;
    #80 o_sck = 1'b1;
    #80 o_sck = 1'b0;
    #40;
  endtask : clr
endmodule : sec_host_model

/* File: testbench/sec_eeprom_asserts.sv */
// Checker of the serial EEPROM command interface pins.
// Assumes it is bound to sec_eeprom and that the link clock only runs in frames.
`timescale 1ns/1ps
module sec_eeprom_asserts #(
  parameter int unsigned PROG_CYCLES = 200
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_serial_clock,
  input wire logic i_cs,
  input wire logic i_din,
  input wire logic i_org,
  input wire logic o_dout,
  input wire logic o_dout_oe
);
  import sec_pkg::*;
  localparam int unsigned LATE = PROG_CYCLES + 8;
  logic [5:0]  bit_cnt_r;
  logic [5:0]  bit_cnt_nxt;
  logic [2:0]  sck_r;
  logic [2:0]  sck_nxt;
  logic        cs_r;
  logic        seen_r;
  logic        seen_nxt;
  logic [15:0] fall_cnt_r;
  logic [15:0] fall_cnt_nxt;
  ////////////////////////////////////////
  always_comb begin
    bit_cnt_nxt = (bit_cnt_r == 6'h3f) ? bit_cnt_r : bit_cnt_r + 6'h01;
  end
  always_ff @(posedge i_serial_clock or negedge i_cs) begin
    if (!i_cs) bit_cnt_r <= 6'h00;
    else bit_cnt_r <= bit_cnt_nxt;
  end
  // The link clock is synchronised so a half-settled level never counts as an edge.
  always_comb begin
    sck_nxt = {sck_r[1:0], i_serial_clock};
    seen_nxt = i_cs && (seen_r || (sck_r[1] && !sck_r[2]));
    fall_cnt_nxt = (cs_r && !i_cs) ? 16'h0000 : fall_cnt_r + {15'h0000, fall_cnt_r != 16'hffff};
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      sck_r <= 3'h0;
      cs_r <= 1'b0;
      seen_r <= 1'b0;
      fall_cnt_r <= 16'hffff;
    end else begin
      sck_r <= sck_nxt;
      cs_r <= i_cs;
      seen_r <= seen_nxt;
      fall_cnt_r <= fall_cnt_nxt;
    end
  end
  ////////////////////////////////////////
  sequence s_read16;
    (bit_cnt_r == 6'h00 && i_din && i_org) ##1 i_din ##1 !i_din ##8 1'b1;
  endsequence
  sequence s_write;
    (bit_cnt_r == 6'h00 && i_din) ##1 !i_din ##1 i_din;
  endsequence
  AST_READ_DUMMY: assert property (@(posedge i_serial_clock) disable iff (!i_rst_n)
    s_read16 |=> o_dout_oe && !o_dout) else $error("read dummy bit missing");
  AST_WRITE_SILENT: assert property (@(posedge i_serial_clock) disable iff (!i_rst_n)
    s_write |=> (!o_dout_oe)[*8]) else $error("output driven in write frame");
  AST_OFF_QUIET: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !o_dout_oe |-> !o_dout) else $error("output high while not driven");
  AST_DESELECT: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_cs [*4] |-> !o_dout_oe) else $error("output driven while deselected");
  AST_WITHHELD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $fell(i_cs) |-> ##3 (!o_dout_oe)[*8]) else $error("status shown too soon");
  AST_READY_NOT_EARLY: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_cs && !seen_r && o_dout_oe && o_dout |-> fall_cnt_r >= PROG_CYCLES)
    else $error("ready before programming time");
  AST_BUSY_NOT_LATE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_cs && !seen_r && o_dout_oe && fall_cnt_r > LATE |-> o_dout)
    else $error("busy after programming time");
  AST_LATE_SELECT: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(i_cs) && fall_cnt_r > LATE |-> (!o_dout_oe)[*4])
    else $error("status shown after late select");
endmodule : sec_eeprom_asserts

/* File: testbench/sec_eeprom_tb_top.sv */
// Self-checking bench of the serial EEPROM command interface.
// Assumes the host model drives the link; the checker is bound to the design.
`timescale 1ns/1ps
module sec_eeprom_tb_top;
  import sec_pkg::*;
  localparam int unsigned PROG = 200;
  logic        i_clk_sys = 1'b0;
  logic        i_rst_n   = 1'b0;
  logic        i_org     = 1'b1;
  wire logic   sck;
  wire logic   cs;
  wire logic   din;
  wire logic   o_dout;
  wire logic   o_dout_oe;
  logic [63:0] got;
  int          err_count = 0;
  int          checks    = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  sec_host_model u_host (.o_sck(sck), .o_cs(cs), .o_din(din), .i_dout(o_dout));
  sec_eeprom #(.PROG_CYCLES(PROG), .ADDR16_W(8)) u_dut (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .i_serial_clock(sck), .i_cs(cs), .i_din(din), .i_org(i_org),
    .o_dout(o_dout), .o_dout_oe(o_dout_oe));
  ////////////////////////////////////////
  task automatic report_and_stop();
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic cmp_word(input string what, input logic [63:0] exp, input logic [63:0] act);
    checks++;
    if (act !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, act);
    end
  endtask : cmp_word
  task automatic cmp_flag(input string what, input logic exp, input logic act);
    checks++;
    if (act !== exp) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", what, exp, act);
    end
  endtask : cmp_flag
  task automatic do_reset(input logic org);
    @(negedge i_clk_sys);
    i_rst_n = 1'b0;
    i_org = org;
    repeat (12) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clk_sys);
  endtask : do_reset
  task automatic cmd(input logic [31:0] bits, input int n);
    u_host.frame(bits, n, 0, -1, got);
  endtask : cmd
  task automatic rd(input logic [8:0] a, input int nout, input int stall);
    if (i_org) u_host.frame({21'h0, 1'b1, 2'b10, a[7:0]}, 11, nout, stall, got);
    else u_host.frame({20'h0, 1'b1, 2'b10, a}, 12, nout, stall, got);
  endtask : rd
  // Polling starts only after the minimum wait past the select fall.
  task automatic prog_wait();
    int n;
    #200;
    @(negedge i_clk_sys);
    u_host.cs_up();
    repeat (4) @(negedge i_clk_sys);
    cmp_flag("busy oe", 1'b1, o_dout_oe);
    cmp_flag("busy level", 1'b0, o_dout);
    n = 0;
    while (o_dout !== 1'b1 && n < PROG + 50) begin
      @(negedge i_clk_sys);
      n++;
    end
    cmp_flag("ready level", 1'b1, o_dout);
    u_host.clr();
    cmp_flag("cleared oe", 1'b0, o_dout_oe);
    u_host.cs_dn();
  endtask : prog_wait
  // Select rises only after the given wait, then stays up long enough to catch any status.
  task automatic no_status(input int pre);
    #200;
    repeat (pre) @(negedge i_clk_sys);
    @(negedge i_clk_sys);
    u_host.cs_up();
    repeat (30) @(negedge i_clk_sys);
    cmp_flag("idle oe", 1'b0, o_dout_oe);
    u_host.cs_dn();
  endtask : no_status
  ////////////////////////////////////////
  task automatic t_locked();
    cmd(32'h480, 11);
    no_status(0);
  endtask : t_locked
  task automatic t_clear();
    cmd(32'h4c0, 11);
    cmd(32'h480, 11);
    prog_wait();
    rd(9'h010, 16, 4);
    cmp_word("clear read", 64'h0ffff, got);
  endtask : t_clear
  task automatic t_fill();
    cmd({5'h0, 1'b1, 2'b00, 8'h40, 16'h1234}, 27);
    prog_wait();
    cmd({21'h0, 1'b1, 2'b11, 8'h01}, 11);
    prog_wait();
    rd(9'h000, 48, -1);
    cmp_word("fill read", {15'h0, 1'b0, 16'h1234, 16'hffff, 16'h1234}, got);
    cmd(32'h400, 11);
  endtask : t_fill
  task automatic t_wrap();
    cmd(32'h4c0, 11);
    cmd({5'h0, 1'b1, 2'b01, 8'hff, 16'ha5c3}, 27);
    prog_wait();
    rd(9'h0ff, 32, -1);
    cmp_word("wrap read", {31'h0, 1'b0, 16'ha5c3, 16'h1234}, got);
  endtask : t_wrap
  task automatic t_late();
    cmd({5'h0, 1'b1, 2'b01, 8'h03, 16'h0f0f}, 27);
    no_status(PROG + 100);
    rd(9'h003, 16, -1);
    cmp_word("late read", 64'h0f0f, got);
  endtask : t_late
  task automatic t_overrun();
    cmd({4'h0, 1'b1, 2'b01, 8'h03, 16'h1111, 1'b0}, 28);
    no_status(0);
    rd(9'h003, 16, -1);
    cmp_word("overrun read", 64'h0f0f, got);
    cmd(32'h800, 12);
    cmd({5'h0, 1'b1, 2'b01, 8'h03, 16'h2222}, 27);
    no_status(0);
    rd(9'h003, 16, -1);
    cmp_word("locked read", 64'h0f0f, got);
  endtask : t_overrun
  task automatic t_x8();
    rd(9'h004, 16, -1);
    cmp_word("byte read", 64'h3412, got);
    cmd(32'h980, 12);
    cmd({12'h0, 1'b1, 2'b01, 9'h005, 8'h5a}, 20);
    prog_wait();
    rd(9'h004, 16, -1);
    cmp_word("byte write", 64'h345a, got);
  endtask : t_x8
  ////////////////////////////////////////
  initial begin
    do_reset(1'b1);
    t_locked();
    t_clear();
    t_fill();
    t_wrap();
    t_late();
    t_overrun();
    do_reset(1'b0);
    t_x8();
    report_and_stop();
  end
  initial begin
    #900000;
    err_count++;
    report_and_stop();
  end
endmodule : sec_eeprom_tb_top

bind sec_eeprom sec_eeprom_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n), .i_serial_clock(i_serial_clock), .i_cs(i_cs), .i_din(i_din),
  .i_org(i_org), .o_dout(o_dout), .o_dout_oe(o_dout_oe));
